/* File: logic/nfh_pkg.sv */
/*
 * nfh_pkg: constants for the host-side command sequencer of a parallel NOR flash.
 * Assumes one 250 MHz clock domain; the flash is driven through asynchronous strobes.
 */
// Functional notes
// - Program resume, erase suspend and erase resume are one write at any address.
// - In bypass mode erase omits unlock cycles: 80 then 10, or 80 then 30.
// - After block erase, extra 30 cycles at block addresses queue more blocks.
// - Blank check: unlock, EB, 76, 00, 00 at block offset 0; 29 confirms.
// - Buffer confirm goes to the same block address as cycles three and four.
// - Buffer sequence at most 261/517 cycles, bypass form 259/515.
// - Count field is units minus one; buffer holds 256 bytes or 512 words.
// - Upper address held during buffer load; low bits select the entry.
// - Buffer abort error is cleared only by the three-cycle reset.
// - Bypass mode is left only by the two-cycle bypass reset 90, 00.
// - Auto select entry is two unlock cycles then 90.
package nfh_pkg;
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CD_UNLK1 = 8'haa;
	localparam logic [7:0] CD_UNLK2 = 8'h55;
	localparam logic [7:0] CD_RESET = 8'hf0;
	localparam logic [7:0] CD_CFI = 8'h98;
	localparam logic [7:0] CD_ASEL = 8'h90;
	localparam logic [7:0] CD_BYP = 8'h20;
	localparam logic [7:0] CD_BYP_RST2 = 8'h00;
	localparam logic [7:0] CD_PROG = 8'ha0;
	localparam logic [7:0] CD_BUF = 8'h25;
	localparam logic [7:0] CD_BUF_CONF = 8'h29;
	localparam logic [7:0] CD_SUSP = 8'hb0;
	localparam logic [7:0] CD_RESUME = 8'h30;
	localparam logic [7:0] CD_ERASE = 8'h80;
	localparam logic [7:0] CD_CHIP = 8'h10;
	localparam logic [7:0] CD_BLK = 8'h30;
	localparam logic [7:0] CD_BC1 = 8'heb;
	localparam logic [7:0] CD_BC2 = 8'h76;
	localparam logic [7:0] CD_ZERO = 8'h00;
	// ----------------------------------------------------------------
	// unlock addresses
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] UA1_W = 26'h0000555;
	localparam logic [ADDR_W-1:0] UA2_W = 26'h00002aa;
	localparam logic [ADDR_W-1:0] UA1_B = 26'h0000aaa;
	localparam logic [ADDR_W-1:0] UA2_B = 26'h0000555;
	// ----------------------------------------------------------------
	// buffer limits
	// ----------------------------------------------------------------
	localparam int BUF_MAX_B = 256;
	localparam int BUF_MAX_W = 512;
	localparam int SEQ_MAX_B = 261;
	localparam int SEQ_MAX_W = 517;
	localparam int SEQ_BYP_MAX_B = 259;
	localparam int SEQ_BYP_MAX_W = 515;
	localparam int BUF_LOW_W = 9;
	localparam int BUF_LOW_B = 8;
	// ----------------------------------------------------------------
	// bus timing
	// ----------------------------------------------------------------
	localparam int CLK_PS = 4000;
	localparam int T_WP_NS = 40;
	localparam int T_WPH_NS = 20;
	localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int WPH_CYC = (T_WPH_NS * 1000 + CLK_PS - 1) / CLK_PS;
	// ----------------------------------------------------------------
	// host commands
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		NFH_OP_RESET1 = 4'h0,
		NFH_OP_RESET3 = 4'h1,
		NFH_OP_CFI = 4'h2,
		NFH_OP_ASEL = 4'h3,
		NFH_OP_BYP_ENTER = 4'h4,
		NFH_OP_BYP_EXIT = 4'h5,
		NFH_OP_PROG = 4'h6,
		NFH_OP_BUF = 4'h7,
		NFH_OP_SUSP = 4'h8,
		NFH_OP_RESUME = 4'h9,
		NFH_OP_CHIP_ER = 4'ha,
		NFH_OP_BLK_ER = 4'hb,
		NFH_OP_BLANK = 4'hc,
		NFH_OP_BLANK_GO = 4'hd,
		NFH_OP_BLK_ADD = 4'he
	} nfh_op_t;
	typedef enum logic [1:0] {
		NFH_MD_READ = 2'h0,
		NFH_MD_ASEL = 2'h1,
		NFH_MD_CFI = 2'h3
	} nfh_mode_t;
endpackage : nfh_pkg

/* File: logic/nfh_wcycle.sv */
/*
 * nfh_wcycle: drives one asynchronous flash write cycle (ce, we low, then high).
 * Assumes outputs go straight to flash pins; oe stays high during writes.
 */
`timescale 1ns/1ps
module nfh_wcycle
	import nfh_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic go_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] data_i,
	output logic idle_o,
	output logic ce_n_o,
	output logic we_n_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic [DATA_W-1:0] dq_o,
	output logic dq_oe_o
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic [1:0] ph_ff;
	logic [1:0] nxt_ph;
	logic low_done;
	logic high_done;

	// phase 0 idle, 1 strobe low, 2 strobe high recovery
	assign low_done = (ph_ff == 2'h1) && (cnt_ff == 8'(WP_CYC - 1));
	assign high_done = (ph_ff == 2'h2) && (cnt_ff == 8'(WPH_CYC - 1));
	assign idle_o = (ph_ff == 2'h0);
	assign nxt_ph = (idle_o && go_i) ? 2'h1 : low_done ? 2'h2 : high_done ? 2'h0 : ph_ff;
	assign nxt_cnt = (low_done || high_done || idle_o) ? 8'h00 : cnt_ff + 8'h01;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ph_ff <= 2'h0;
			cnt_ff <= 8'h00;
			ce_n_o <= 1'b1;
			we_n_o <= 1'b1;
			addr_o <= '0;
			dq_o <= '0;
			dq_oe_o <= 1'b0;
		end else begin
			ph_ff <= nxt_ph;
			cnt_ff <= nxt_cnt;
			ce_n_o <= (nxt_ph == 2'h0);
			we_n_o <= (nxt_ph != 2'h1);
			dq_oe_o <= (nxt_ph != 2'h0);
			if (idle_o && go_i) begin
				addr_o <= addr_i;
				dq_o <= data_i;
			end
		end
	end
endmodule : nfh_wcycle

/* File: logic/nfh_seq.sv */
/*
 * nfh_seq: host sequencer that expands one command request into the
 * flash address-data write cycles, tracking the device mode it implies.
 * Assumes the user holds req until ack, and supplies buffer data on demand.
 */
`timescale 1ns/1ps
module nfh_seq
	import nfh_pkg::*;
#(
	parameter int BUF_DEPTH_W = BUF_MAX_W
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic byte_mode_i,
	input wire logic req_i,
	input wire nfh_op_t op_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] data_i,
	input wire logic [9:0] count_i,
	input wire logic busy_i,
	input wire logic abort_err_i,
	output logic ack_o,
	output logic reject_o,
	output logic data_req_o,
	output logic [9:0] data_idx_o,
	output logic bypass_o,
	output logic [1:0] mode_o,
	output logic suspended_o,
	output logic ce_n_o,
	output logic we_n_o,
	output logic oe_n_o,
	output logic [ADDR_W-1:0] fl_addr_o,
	output logic [DATA_W-1:0] fl_dq_o,
	output logic fl_dq_oe_o
);
	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		NFH_ST_IDLE = 2'b00,
		NFH_ST_ISSUE = 2'b01,
		NFH_ST_WAIT = 2'b11,
		NFH_ST_DONE = 2'b10
	} nfh_st_t;

	nfh_st_t st_ff;
	nfh_st_t nxt_st;
	nfh_op_t op_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] data_ff;
	logic [9:0] cnt_ff;
	logic [9:0] step_ff;
	logic [9:0] last_step;
	logic bypass_ff;
	logic [1:0] mode_ff;
	logic susp_ff;
	logic wc_idle;
	logic wc_go;
	logic [ADDR_W-1:0] cyc_addr;
	logic [7:0] cyc_code;
	logic [ADDR_W-1:0] ua1;
	logic [ADDR_W-1:0] ua2;
	logic [ADDR_W-1:0] blk_base;
	logic [ADDR_W-1:0] buf_addr;
	logic [DATA_W-1:0] cyc_data;
	logic accept;
	logic refuse;
	logic last_cyc;
	logic buf_data_cyc;
	logic skip_unlk;
	logic [9:0] code_step;
	logic [9:0] buf_first;
	logic [9:0] buf_ent;

	// unlock address pair for the current bus width
	function automatic logic [ADDR_W-1:0] unlk(input logic second, input logic bm);
		if (bm)
			unlk = second ? UA2_B : UA1_B;
		else
			unlk = second ? UA2_W : UA1_W;
	endfunction : unlk

	assign ua1 = unlk(1'b0, byte_mode_i);
	assign ua2 = unlk(1'b1, byte_mode_i);
	// bypass drops the unlock pair only for program and erase forms
	assign skip_unlk = bypass_ff && (op_ff == NFH_OP_PROG || op_ff == NFH_OP_BUF
		|| op_ff == NFH_OP_CHIP_ER || op_ff == NFH_OP_BLK_ER);
	// bypass erase goes straight from 80 to its subcode
	assign code_step = !skip_unlk ? step_ff
		: ((op_ff == NFH_OP_CHIP_ER || op_ff == NFH_OP_BLK_ER) && step_ff == 10'h001) ? 10'h005
		: 10'(step_ff + 10'h002);
	// first buffer entry follows the 25 and count cycles
	assign buf_first = bypass_ff ? 10'h002 : 10'h004;
	assign buf_ent = 10'(step_ff - buf_first);
	// block offset 0: blank check cycles after the unlock pair, and the 29 confirm, target the block base
	assign blk_base = {addr_ff[ADDR_W-1:16], 16'h0000};
	// upper bits held, low bits walk the entry index
	assign buf_addr = byte_mode_i ? {addr_ff[ADDR_W-1:BUF_LOW_B], buf_ent[7:0]}
		: {addr_ff[ADDR_W-1:BUF_LOW_W], buf_ent[8:0]};

	// ----------------------------------------------------------------
	// cycle count per command
	// ----------------------------------------------------------------
	always_comb begin
		last_step = 10'h000;
		case (op_ff)
			NFH_OP_RESET3, NFH_OP_ASEL, NFH_OP_BYP_ENTER: last_step = 10'h002;
			NFH_OP_BYP_EXIT: last_step = 10'h001;
			NFH_OP_PROG: last_step = bypass_ff ? 10'h001 : 10'h003;
			// header + N+1 data + confirm, bounded by count width
			NFH_OP_BUF: last_step = bypass_ff ? 10'(cnt_ff + 10'h003)
				: 10'(cnt_ff + 10'h005);
			NFH_OP_CHIP_ER, NFH_OP_BLK_ER: last_step = bypass_ff ? 10'h001 : 10'h005;
			NFH_OP_BLANK: last_step = 10'h005;
			default: last_step = 10'h000;
		endcase
	end

	// non-bypass buffer: steps 4..4+N carry the N+1 entries; bypass starts at 2
	assign buf_data_cyc = (op_ff == NFH_OP_BUF) && (step_ff != last_step)
		&& (step_ff >= buf_first);

	// ----------------------------------------------------------------
	// address/code of the current cycle
	// ----------------------------------------------------------------
	always_comb begin
		cyc_addr = addr_ff;
		cyc_code = CD_RESET;
		case (op_ff)
			NFH_OP_RESET1: cyc_code = CD_RESET;
			NFH_OP_SUSP: cyc_code = CD_SUSP;
			NFH_OP_RESUME: cyc_code = CD_RESUME;
			NFH_OP_CFI: begin
				cyc_addr = ua1;
				cyc_code = CD_CFI;
			end
			NFH_OP_BYP_EXIT: cyc_code = (step_ff == 10'h000) ? CD_ASEL : CD_BYP_RST2;
			NFH_OP_BLANK_GO: begin
				cyc_addr = blk_base;
				cyc_code = CD_BUF_CONF;
			end
			NFH_OP_BLK_ADD: cyc_code = CD_BLK;
			default: begin
				if (!skip_unlk && step_ff == 10'h000) begin
					cyc_addr = ua1;
					cyc_code = CD_UNLK1;
				end else if (!skip_unlk && step_ff == 10'h001) begin
					cyc_addr = ua2;
					cyc_code = CD_UNLK2;
				end else begin
					cyc_addr = ua1;
					cyc_code = op_code(op_ff, code_step);
					if (op_ff == NFH_OP_BLANK)
						cyc_addr = blk_base;
					else if (op_ff == NFH_OP_BUF)
						cyc_addr = buf_data_cyc ? buf_addr : addr_ff;
					else if (op_ff == NFH_OP_BLK_ER && step_ff == last_step)
						cyc_addr = addr_ff;
					else if (op_ff == NFH_OP_PROG && step_ff == last_step)
						cyc_addr = addr_ff;
					else if (op_ff == NFH_OP_CHIP_ER && bypass_ff)
						cyc_addr = addr_ff;
				end
			end
		endcase
	end

	// code of the step-th cycle with unlock steps counted (bypass adds two)
	function automatic logic [7:0] op_code(input nfh_op_t op, input logic [9:0] s);
		op_code = CD_ZERO;
		case (op)
			NFH_OP_RESET3: op_code = CD_RESET;
			NFH_OP_ASEL: op_code = CD_ASEL;
			NFH_OP_BYP_ENTER: op_code = CD_BYP;
			NFH_OP_PROG: op_code = CD_PROG;
			NFH_OP_BUF: op_code = (s == 10'h002) ? CD_BUF : CD_ZERO;
			NFH_OP_CHIP_ER, NFH_OP_BLK_ER: begin
				case (s)
					10'h002: op_code = CD_ERASE;
					10'h003: op_code = CD_UNLK1;
					10'h004: op_code = CD_UNLK2;
					default: op_code = (op == NFH_OP_CHIP_ER) ? CD_CHIP : CD_BLK;
				endcase
			end
			NFH_OP_BLANK: begin
				case (s)
					10'h002: op_code = CD_BC1;
					10'h003: op_code = CD_BC2;
					default: op_code = CD_ZERO;
				endcase
			end
			default: op_code = CD_ZERO;
		endcase
	endfunction : op_code

	// second erase unlock pair sits at unlock addresses
	logic er_unlk;
	assign er_unlk = !bypass_ff && (op_ff == NFH_OP_CHIP_ER || op_ff == NFH_OP_BLK_ER)
		&& (step_ff == 10'h003 || step_ff == 10'h004);

	// buffer header: 25 at block, count at block, data, then confirm
	// single program carries its data on the last cycle
	assign cyc_data = buf_data_cyc ? data_ff
		: (op_ff == NFH_OP_PROG && step_ff == last_step) ? data_ff
		: (op_ff == NFH_OP_BUF && step_ff == last_step) ? {8'h00, CD_BUF_CONF}
		: (op_ff == NFH_OP_BUF && step_ff == (bypass_ff ? 10'h001 : 10'h003))
			? {6'h00, cnt_ff} : {8'h00, cyc_code};

	// ----------------------------------------------------------------
	// acceptance of requests
	// ----------------------------------------------------------------
	// reset forms are withheld while the device works; auto select too unless suspended
	assign refuse = (busy_i && (op_i == NFH_OP_RESET1 || op_i == NFH_OP_RESET3))
		|| (busy_i && !susp_ff && op_i == NFH_OP_ASEL)
		|| (op_i == NFH_OP_CFI && mode_ff == NFH_MD_CFI)
		|| (abort_err_i && op_i == NFH_OP_RESET1);
	assign accept = (st_ff == NFH_ST_IDLE) && req_i && !refuse;
	assign reject_o = (st_ff == NFH_ST_IDLE) && req_i && refuse;
	assign last_cyc = (step_ff == last_step);
	assign wc_go = (st_ff == NFH_ST_ISSUE);
	assign data_req_o = (st_ff == NFH_ST_WAIT) && wc_idle && !last_cyc && (op_ff == NFH_OP_BUF)
		&& (step_ff + 10'h001 >= buf_first)
		&& (step_ff + 10'h001 != last_step);
	assign data_idx_o = 10'(step_ff + 10'h001 - buf_first);
	assign ack_o = (st_ff == NFH_ST_DONE);

	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			NFH_ST_IDLE: nxt_st = accept ? NFH_ST_ISSUE : NFH_ST_IDLE;
			NFH_ST_ISSUE: nxt_st = NFH_ST_WAIT;
			NFH_ST_WAIT: nxt_st = !wc_idle ? NFH_ST_WAIT : last_cyc ? NFH_ST_DONE : NFH_ST_ISSUE;
			NFH_ST_DONE: nxt_st = NFH_ST_IDLE;
			default: nxt_st = NFH_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= NFH_ST_IDLE;
			op_ff <= NFH_OP_RESET1;
			addr_ff <= '0;
			data_ff <= '0;
			cnt_ff <= 10'h000;
			step_ff <= 10'h000;
		end else begin
			st_ff <= nxt_st;
			if (accept) begin
				op_ff <= op_i;
				addr_ff <= addr_i;
				data_ff <= data_i;
				// count clipped to buffer size for the bus width
				cnt_ff <= (byte_mode_i && count_i >= 10'(BUF_MAX_B)) ? 10'(BUF_MAX_B - 1)
					: (count_i >= 10'(BUF_DEPTH_W)) ? 10'(BUF_DEPTH_W - 1) : count_i;
				step_ff <= 10'h000;
			end else if (st_ff == NFH_ST_WAIT && wc_idle && !last_cyc) begin
				step_ff <= step_ff + 10'h001;
				if (data_req_o)
					data_ff <= data_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// device mode tracking
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_ff <= NFH_MD_READ;
			bypass_ff <= 1'b0;
			susp_ff <= 1'b0;
		end else if (ack_o) begin
			case (op_ff)
				NFH_OP_RESET1, NFH_OP_RESET3: mode_ff <= NFH_MD_READ;
				NFH_OP_CFI: mode_ff <= NFH_MD_CFI;
				NFH_OP_ASEL: mode_ff <= NFH_MD_ASEL;
				NFH_OP_BYP_ENTER: bypass_ff <= 1'b1;
				NFH_OP_BYP_EXIT: bypass_ff <= 1'b0;
				NFH_OP_SUSP: susp_ff <= 1'b1;
				NFH_OP_RESUME: susp_ff <= 1'b0;
				default: mode_ff <= mode_ff;
			endcase
		end
	end

	assign bypass_o = bypass_ff;
	assign mode_o = mode_ff;
	assign suspended_o = susp_ff;
	assign oe_n_o = 1'b1;

	nfh_wcycle u_wc (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.go_i(wc_go),
		.addr_i(er_unlk ? ((step_ff == 10'h003) ? ua1 : ua2) : cyc_addr),
		.data_i(cyc_data),
		.idle_o(wc_idle),
		.ce_n_o(ce_n_o),
		.we_n_o(we_n_o),
		.addr_o(fl_addr_o),
		.dq_o(fl_dq_o),
		.dq_oe_o(fl_dq_oe_o)
	);
endmodule : nfh_seq

/* File: testbench/nfh_seq_asserts.sv */
/* nfh_seq_chk: port checks of the flash command sequencer.
   Assumes it is bound into nfh_seq and sees only its ports. */
`timescale 1ns/1ps
module nfh_seq_chk
	import nfh_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire nfh_op_t op_i,
	input wire logic busy_i,
	input wire logic abort_err_i,
	input wire logic ack_o,
	input wire logic reject_o,
	input wire logic bypass_o,
	input wire logic [1:0] mode_o,
	input wire logic suspended_o,
	input wire logic ce_n_o,
	input wire logic we_n_o,
	input wire logic oe_n_o,
	input wire logic [ADDR_W-1:0] fl_addr_o,
	input wire logic [DATA_W-1:0] fl_dq_o,
	input wire logic fl_dq_oe_o
);
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic is_rst = op_i inside {NFH_OP_RESET1, NFH_OP_RESET3};
	we_in_ce_a: assert property (!we_n_o |-> !ce_n_o && fl_dq_oe_o && oe_n_o)
		else $error("write strobe outside select");
	we_width_a: assert property ($fell(we_n_o) |-> ##10 $rose(we_n_o))
		else $error("write low time wrong");
	wr_stable_a: assert property (!we_n_o && !$past(we_n_o) |-> $stable(fl_addr_o))
		else $error("address moved in write");
	rst_busy_a: assert property (req_i && is_rst && busy_i |-> !ack_o && ce_n_o)
		else $error("reset taken while busy");
	abort_one_a: assert property (req_i && op_i == NFH_OP_RESET1 && abort_err_i |-> !ack_o)
		else $error("short reset taken on abort");
	asel_busy_a: assert property (req_i && op_i == NFH_OP_ASEL && busy_i && !suspended_o
		|-> !ack_o)
		else $error("autoselect taken while busy");
	cfi_mode_a: assert property (ack_o && op_i == NFH_OP_CFI |=> mode_o == NFH_MD_CFI)
		else $error("cfi mode not entered");
	asel_mode_a: assert property (ack_o && op_i == NFH_OP_ASEL |=> mode_o == NFH_MD_ASEL)
		else $error("autoselect not entered");
	rst_mode_a: assert property (ack_o && is_rst |=> mode_o == NFH_MD_READ)
		else $error("reset left mode");
	byp_keep_a: assert property (ack_o && is_rst |=> bypass_o == $past(bypass_o))
		else $error("reset changed bypass");
	byp_exit_a: assert property (ack_o && op_i == NFH_OP_BYP_EXIT |=> !bypass_o)
		else $error("bypass not left");
	reject_idle_a: assert property (reject_o |-> req_i && ce_n_o && !ack_o)
		else $error("refusal with activity");
	cover property (ack_o && op_i == NFH_OP_CFI);
	cover property (reject_o && is_rst);
	cover property (ack_o && op_i == NFH_OP_BUF);
endmodule : nfh_seq_chk
bind nfh_seq nfh_seq_chk u_chk (.clk_i, .rst_n_i, .req_i, .op_i, .busy_i, .abort_err_i, .ack_o,
	.reject_o, .bypass_o, .mode_o, .suspended_o, .ce_n_o, .we_n_o, .oe_n_o, .fl_addr_o,
	.fl_dq_o, .fl_dq_oe_o);

/* File: testbench/nfh_flash_model.sv */
/* nfh_flash_model: behavioural flash seen from its write pins.
   Assumes the host clock; a write lands on the rising write strobe. */
`timescale 1ns/1ps
module nfh_flash_model
	import nfh_pkg::*;
#(
	parameter int BUSY_CYC = 200
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_n_i,
	input wire logic we_n_i,
	input wire logic [DATA_W-1:0] dq_i,
	input wire logic abort_set_i,
	output logic busy_o,
	output logic abort_err_o
);
	logic we_q_ff;
	logic er_ff;
	logic pg_ff;
	logic susp_ff;
	logic [7:0] d1_ff;
	logic [7:0] cnt_ff;
	wire logic wr = !we_q_ff && we_n_i && !ce_n_i;
	wire logic [7:0] d = dq_i[7:0];
	wire logic go = pg_ff || d == CD_BUF_CONF || (er_ff && d inside {CD_CHIP, CD_BLK});
	// ------------------------------------------------
	// command tracking
	// ------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{we_q_ff, er_ff, pg_ff, susp_ff, busy_o, abort_err_o} <= 6'h20;
			{d1_ff, cnt_ff} <= '0;
		end else begin
			we_q_ff <= we_n_i;
			if (busy_o) cnt_ff <= cnt_ff - 8'h1;
			if (busy_o && cnt_ff == 8'h0) busy_o <= 1'b0;
			if (abort_set_i) abort_err_o <= 1'b1;
			if (wr) begin
				d1_ff <= d;
				pg_ff <= d == CD_PROG;
				er_ff <= d == CD_ERASE || (er_ff && !go);
				if (busy_o && d == CD_SUSP) begin
					busy_o <= 1'b0;
					susp_ff <= 1'b1;
				end else if (susp_ff && d == CD_RESUME) begin
					busy_o <= 1'b1;
					susp_ff <= 1'b0;
					cnt_ff <= 8'(BUSY_CYC);
				end else if (!busy_o && go) begin
					busy_o <= 1'b1;
					cnt_ff <= 8'(BUSY_CYC);
				end else if (!busy_o && d == CD_RESET && d1_ff == CD_UNLK2) begin
					abort_err_o <= 1'b0;
				end
			end
		end
	end
endmodule : nfh_flash_model

/* File: testbench/tb_top.sv */
/* tb_top: self-checking bench for the flash command sequencer.
   Assumes default buffer depth and the behavioural flash model. */
`timescale 1ns/1ps
module tb_top
	import nfh_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic byte_mode_i = 1'b0;
	logic req_i = 1'b0;
	nfh_op_t op_i = NFH_OP_RESET1;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [DATA_W-1:0] data_i = '0;
	logic [9:0] count_i = '0;
	logic abort_set = 1'b0;
	logic busy_i, abort_err_i, ack_o, reject_o, data_req_o, bypass_o, suspended_o;
	logic ce_n_o, we_n_o, oe_n_o, fl_dq_oe_o;
	logic [9:0] data_idx_o;
	logic [1:0] mode_o;
	logic [ADDR_W-1:0] fl_addr_o;
	logic [DATA_W-1:0] fl_dq_o;
	logic [ADDR_W-1:0] ad;
	logic [DATA_W-1:0] dt;
	logic [34:0] ee;
	logic [34:0] exp_q[$];
	logic we_q = 1'b1;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int nld = 0;
	int ld_base = 0;
	always #2 clk_i = ~clk_i;
	nfh_seq uut (.clk_i, .rst_n_i, .byte_mode_i, .req_i, .op_i, .addr_i, .data_i, .count_i,
		.busy_i, .abort_err_i, .ack_o, .reject_o, .data_req_o, .data_idx_o, .bypass_o, .mode_o,
		.suspended_o, .ce_n_o, .we_n_o, .oe_n_o, .fl_addr_o, .fl_dq_o, .fl_dq_oe_o);
	nfh_flash_model dev (.clk_i, .rst_n_i, .ce_n_i(ce_n_o), .we_n_i(we_n_o), .dq_i(fl_dq_o),
		.abort_set_i(abort_set), .busy_o(busy_i), .abort_err_o(abort_err_i));
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic chk(input string nm, input logic [25:0] e, input logic [25:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wrap_up();
		chk("left", '0, 26'(exp_q.size()));
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	function automatic void ex(input logic c, input logic [25:0] a, input logic [7:0] d);
		exp_q.push_back({c, a, d});
	endfunction : ex
	// bit 7 kept low so buffer data never looks like an 80, A0, B0 or F0 command to the model
	task automatic rnd();
		ad = 26'($urandom);
		dt = 16'($urandom) & 16'h7f7f;
	endtask : rnd
	task automatic idle();
		int i;
		i = 0;
		while (busy_i !== 1'b0 && i < 2000) begin
			@(posedge clk_i);
			i++;
		end
		chk("idle", '0, 26'(busy_i));
	endtask : idle
	// expected writes are noted before the request goes out
	task automatic cmd(input nfh_op_t op, input logic rj = 1'b0, input logic [9:0] n = '0);
		logic [25:0] u1;
		logic [25:0] u2;
		logic [25:0] blk;
		int m;
		int i;
		u1 = byte_mode_i ? UA1_B : UA1_W;
		u2 = byte_mode_i ? UA2_B : UA2_W;
		blk = {ad[25:16], 16'h0};
		m = byte_mode_i ? (n > 255 ? 255 : n) : (n > 511 ? 511 : n);
		if (!rj && (op inside {NFH_OP_RESET3, NFH_OP_ASEL, NFH_OP_BYP_ENTER, NFH_OP_BLANK}
			|| (!bypass_o && op inside {NFH_OP_PROG, NFH_OP_BUF, NFH_OP_CHIP_ER,
			NFH_OP_BLK_ER}))) begin
			ex(1'b1, u1, CD_UNLK1);
			ex(1'b1, u2, CD_UNLK2);
		end
		if (!rj) case (op)
			NFH_OP_RESET1, NFH_OP_RESET3: ex(1'b0, u1, CD_RESET);
			NFH_OP_CFI: ex(1'b1, u1, CD_CFI);
			NFH_OP_ASEL: ex(1'b1, u1, CD_ASEL);
			NFH_OP_BYP_ENTER: ex(1'b1, u1, CD_BYP);
			NFH_OP_BYP_EXIT: begin
				ex(1'b0, u1, CD_ASEL);
				ex(1'b0, u1, CD_BYP_RST2);
			end
			NFH_OP_PROG: begin
				ex(!bypass_o, u1, CD_PROG);
				ex(1'b1, ad, dt[7:0]);
			end
			NFH_OP_SUSP: ex(1'b0, u1, CD_SUSP);
			NFH_OP_RESUME: ex(1'b0, u1, CD_RESUME);
			NFH_OP_CHIP_ER, NFH_OP_BLK_ER: begin
				ex(!bypass_o, u1, CD_ERASE);
				if (!bypass_o) begin
					ex(1'b1, u1, CD_UNLK1);
					ex(1'b1, u2, CD_UNLK2);
				end
				if (op == NFH_OP_CHIP_ER) ex(!bypass_o, u1, CD_CHIP);
				else ex(1'b1, ad, CD_BLK);
			end
			NFH_OP_BLK_ADD: ex(1'b1, ad, CD_BLK);
			NFH_OP_BLANK: begin
				ex(1'b1, blk, CD_BC1);
				ex(1'b1, blk, CD_BC2);
				ex(1'b1, blk, CD_ZERO);
				ex(1'b1, blk, CD_ZERO);
			end
			NFH_OP_BLANK_GO: ex(1'b1, blk, CD_BUF_CONF);
			default: begin
				ex(1'b1, ad, CD_BUF);
				ex(1'b1, ad, m[7:0]);
				for (int k = 0; k <= m; k++)
					ex(1'b1, byte_mode_i ? {ad[25:8], 8'(k)} : {ad[25:9], 9'(k)}, dt[7:0]);
				ex(1'b1, ad, CD_BUF_CONF);
			end
		endcase
		ld_base = nld;
		@(posedge clk_i);
		op_i <= op;
		addr_i <= ad;
		data_i <= dt;
		count_i <= n;
		req_i <= 1'b1;
		i = 0;
		while (!(ack_o || reject_o) && i < 20000) begin
			@(posedge clk_i);
			i++;
		end
		chk("answer", 26'h1, 26'(ack_o || reject_o));
		chk("reject", 26'(rj), 26'(reject_o));
		if (op == NFH_OP_BUF && !rj)
			chk("entries", 26'(m + 1), 26'(nld - ld_base));
		req_i <= 1'b0;
		@(posedge clk_i);
	endtask : cmd
	// ------------------------------------------------
	// write cycle monitor, data request check and watchdog
	// ------------------------------------------------
	always @(posedge clk_i) begin
		we_q <= we_n_o;
		if (rst_n_i && !we_q && we_n_o) begin
			if (exp_q.size() == 0) begin
				chk("extra", '0, 26'h1);
			end else begin
				ee = exp_q.pop_front();
				chk("data", 26'(ee[7:0]), 26'(fl_dq_o[7:0]));
				if (ee[34]) chk("addr", ee[33:8], fl_addr_o);
			end
		end
		if (rst_n_i && data_req_o) begin
			chk("index", 26'(nld - ld_base), 26'(data_idx_o));
			nld <= nld + 1;
		end
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(11761));
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		chk("mode", NFH_MD_READ, mode_o);
		chk("strobes", 26'h3, {ce_n_o, we_n_o});
		for (int b = 0; b < 2; b++) begin
			byte_mode_i <= b[0];
			@(posedge clk_i);
			rnd();
			cmd(NFH_OP_RESET1);
			cmd(NFH_OP_RESET3);
			cmd(NFH_OP_CFI);
			chk("mode", NFH_MD_CFI, mode_o);
			cmd(NFH_OP_CFI, 1'b1);
			cmd(NFH_OP_RESET1);
			chk("mode", NFH_MD_READ, mode_o);
			cmd(NFH_OP_ASEL);
			chk("mode", NFH_MD_ASEL, mode_o);
			cmd(NFH_OP_CFI);
			chk("mode", NFH_MD_CFI, mode_o);
			cmd(NFH_OP_RESET3);
			chk("mode", NFH_MD_READ, mode_o);
			cmd(NFH_OP_BUF, 1'b0, b[0] ? 10'd300 : 10'd511);
			idle();
		end
		byte_mode_i <= 1'b0;
		@(posedge clk_i);
		cmd(NFH_OP_PROG);
		idle();
		cmd(NFH_OP_BYP_ENTER);
		chk("bypass", 26'h1, bypass_o);
		cmd(NFH_OP_CHIP_ER);
		idle();
		rnd();
		cmd(NFH_OP_BLK_ER);
		idle();
		cmd(NFH_OP_PROG);
		idle();
		cmd(NFH_OP_BUF, 1'b0, 10'($urandom_range(7)));
		idle();
		cmd(NFH_OP_RESET1);
		chk("bypass", 26'h1, bypass_o);
		cmd(NFH_OP_BYP_EXIT);
		chk("bypass", 26'h0, bypass_o);
		cmd(NFH_OP_BLK_ER);
		rnd();
		cmd(NFH_OP_BLK_ADD);
		cmd(NFH_OP_RESET1, 1'b1);
		cmd(NFH_OP_ASEL, 1'b1);
		cmd(NFH_OP_SUSP);
		cmd(NFH_OP_ASEL);
		cmd(NFH_OP_RESET3);
		chk("suspend", 26'h1, suspended_o);
		cmd(NFH_OP_RESUME);
		idle();
		cmd(NFH_OP_CHIP_ER);
		idle();
		cmd(NFH_OP_BLANK);
		cmd(NFH_OP_BLANK_GO);
		idle();
		abort_set <= 1'b1;
		@(posedge clk_i);
		abort_set <= 1'b0;
		cmd(NFH_OP_RESET1, 1'b1);
		cmd(NFH_OP_RESET3);
		chk("abort", 26'h0, 26'(abort_err_i));
		repeat (4) @(posedge clk_i);
		wrap_up();
	end
endmodule : tb_top
